// ---- rtl/fcsp_pkg.sv ----
// Function
// [RQ1] status readable anytime at command address; reads status, writes go to command
// [RQ2] status top two bits always read zero; code in low six bits
// [RQ3] unlock codes: locked 0, first 1, second 2, unlocked 3
// [RQ4] code 000100 after protect-access command until next shared-address write
// [RQ5] program 001xxx, page erase 010xxx, mass erase 100xxx while running
// [RQ6] shared-address writes go to page select unless protect access armed
// [RQ7] only the single next shared write after arming hits sector lock
// [RQ8] page spans 512 bytes; erase hits addresses whose top seven bits match
// [RQ9] page field bits 6:0 drive program address bits 15:9
// [RQ10] page select bit 7 maps information area at FE00 to FFFF
// [RQ11] eight sector lock bits, all reset to zero
// [RQ12] sector lock bits once set cannot be cleared by writes
// [RQ13] sector size 1024 bytes on largest variant, else 512
// [RQ14] timing value is high byte concatenated over low byte
// [RQ15] software loads timing value with clock in kilohertz
// [RQ16] software avoids program or erase outside 20 kHz to 20 MHz; the testbench erases and programs at 40 MHz
// [RQ17] option data copied from flash into holding registers during reset
// [RQ18] unlock by 73 then 8C; anything else relocks
// [RQ19] command 5E while unlocked enables sector lock access
// [RQ20] program and erase blocked on locked sectors; mass erase is not checked against sector lock
// [RQ21] 95 third starts page erase, 63 third starts mass erase
// [RQ22] sector lock write ORs data into existing bits
// [RQ23] page select and timing bytes reset zero; status reports locked
package fcsp_pkg;
   localparam logic [11:0] FCSP_ADDR_STATE  = 12'h0ff8;
   localparam logic [11:0] FCSP_ADDR_PAGE   = 12'h0ff9;
   localparam logic [11:0] FCSP_ADDR_TIME_H = 12'h0ffa;
   localparam logic [11:0] FCSP_ADDR_TIME_L = 12'h0ffb;
   localparam logic [7:0]  FCSP_CMD_UNLOCK1 = 8'h0073;
   localparam logic [7:0]  FCSP_CMD_UNLOCK2 = 8'h008c;
   localparam logic [7:0]  FCSP_CMD_PAGE_ER = 8'h0095;
   localparam logic [7:0]  FCSP_CMD_MASS_ER = 8'h0063;
   localparam logic [7:0]  FCSP_CMD_PROTECT = 8'h005e;
   localparam logic [5:0]  FCSP_ST_LOCKED   = 6'h00;
   localparam logic [5:0]  FCSP_ST_FIRST    = 6'h01;
   localparam logic [5:0]  FCSP_ST_SECOND   = 6'h02;
   localparam logic [5:0]  FCSP_ST_UNLOCKED = 6'h03;
   localparam logic [5:0]  FCSP_ST_PROTSEL  = 6'h04;
   localparam logic [5:0]  FCSP_ST_PROG     = 6'h08;
   localparam logic [5:0]  FCSP_ST_PAGE_ER  = 6'h10;
   localparam logic [5:0]  FCSP_ST_MASS_ER  = 6'h20;
   localparam logic [7:0]  FCSP_RST_BYTE    = 8'h00;
   localparam int          FCSP_PAGE_SHIFT  = 9;
   localparam int          FCSP_INFO_BIT    = 7;
   localparam logic [15:0] FCSP_INFO_BASE   = 16'hfe00;
   localparam int          FCSP_SECT_BIG    = 10;
   localparam int          FCSP_SECT_SMALL  = 9;
   localparam int          FCSP_OPT_BYTES   = 2;
endpackage

// ---- rtl/fcsp_opt_if.sv ----
`timescale 1ns/10ps
// option load handshake between loader and controller
interface fcsp_opt_if;
   logic        req;
   logic [15:0] addr;
   logic [7:0]  data;
   logic        valid;
   logic        done;
   modport loader (output req, output addr, input data, input valid, output done);
   modport ctrl   (input req, input addr, output data, output valid, input done);
endinterface

// ---- rtl/fcsp_opt_loader.sv ----
`timescale 1ns/10ps
// copies option bytes out of flash right after reset release
module fcsp_opt_loader
   import fcsp_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   fcsp_opt_if.loader      opt,
   output logic [15:0]     option_bits
);
   typedef struct packed {
      logic        busy;
      logic [0:0]  idx;
      logic        wait_rd;
      logic [15:0] bits;
   } fcsp_ld_s;
   fcsp_ld_s st_reg, st_next;

   // **************************
   // load sequencer
   // **************************
   always_comb begin
      st_next = st_reg;
      if (st_reg.busy) begin
         if (!st_reg.wait_rd) begin
            st_next.wait_rd = 1'b1;
         end else if (opt.valid) begin
            st_next.wait_rd = 1'b0;
            st_next.bits[st_reg.idx*8 +: 8] = opt.data; // RQ17
            if (st_reg.idx == 1'(FCSP_OPT_BYTES - 1)) begin
               st_next.busy = 1'b0;
            end else begin
               st_next.idx = st_reg.idx + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{busy: 1'b1, idx: 1'b0, wait_rd: 1'b0, bits: 16'h0000};
      end else begin
         st_reg <= st_next;
      end
   end

   assign opt.req     = st_reg.busy & st_reg.wait_rd;
   assign opt.addr    = {15'h0000, st_reg.idx};
   assign opt.done    = ~st_reg.busy;
   assign option_bits = st_reg.bits;
endmodule // fcsp_opt_loader

// ---- rtl/fcsp_sector_guard.sv ----
`timescale 1ns/10ps
// decides whether a program address is writable
module fcsp_sector_guard
   import fcsp_pkg::*;
#(
   parameter int BIG_PART = 1
)(
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  lock_bits,
   input  wire logic [6:0]  page,
   input  wire logic        page_only,
   output logic             allowed
);
   logic [2:0] sect;
   logic       in_page;

   // sector index from address, sized per variant
   assign sect    = BIG_PART != 0 ? addr[FCSP_SECT_BIG +: 3]
                                  : addr[FCSP_SECT_SMALL +: 3]; // RQ13
   assign in_page = addr[15:FCSP_PAGE_SHIFT] == page; // RQ8 RQ9
   assign allowed = !lock_bits[sect] && (!page_only || in_page); // RQ20
endmodule // fcsp_sector_guard

// ---- rtl/fcsp_ctrl.sv ----
`timescale 1ns/10ps
// flash controller register side: status, page select, sector lock, timing
module fcsp_ctrl
   import fcsp_pkg::*;
#(
   parameter int BIG_PART = 1
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   input  wire logic        prog_req,
   input  wire logic [15:0] prog_addr,
   input  wire logic        flash_done,
   output logic             prog_grant,
   output logic             prog_refused,
   output logic             page_erase_go,
   output logic             mass_erase_go,
   output logic [6:0]       erase_page,
   output logic             info_map_en,
   output logic [15:0]      timing_value,
   output logic             opt_rd_req,
   output logic [15:0]      opt_rd_addr,
   input  wire logic [7:0]  opt_rd_data,
   input  wire logic        opt_rd_valid,
   output logic [15:0]      option_bits,
   output logic             option_ready
);
   typedef enum logic [7:0] {
      FCSP_LOCKED   = 8'b0000_0001,
      FCSP_FIRST    = 8'b0000_0010,
      FCSP_SECOND   = 8'b0000_0100,
      FCSP_UNLOCKED = 8'b0000_1000,
      FCSP_PROTSEL  = 8'b0001_0000,
      FCSP_PROG     = 8'b0010_0000,
      FCSP_PAGE_ER  = 8'b0100_0000,
      FCSP_MASS_ER  = 8'b1000_0000
   } fcsp_state_e;

   typedef struct packed {
      fcsp_state_e fsm;
      logic [7:0]  page_select;
      logic [7:0]  sector_lock;
      logic [7:0]  timing_value_high;
      logic [7:0]  timing_value_low;
      logic [7:0]  rdata;
      logic        grant;
      logic        refused;
      logic        page_go;
      logic        mass_go;
      logic        erased_ok;
   } fcsp_ctrl_s;

   fcsp_ctrl_s  st_reg, st_next;
   fcsp_opt_if  opt ();
   logic        addr_ok;
   logic [15:0] opt_bits;
   logic        wr_cmd;
   logic        wr_page;
   logic        wr_hi;
   logic        wr_lo;
   logic [5:0]  code;

   // **************************
   // helpers
   // **************************
   fcsp_opt_loader u_loader (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .opt         (opt.loader),
      .option_bits (opt_bits)
   );

   fcsp_sector_guard #(.BIG_PART(BIG_PART)) u_guard (
      .addr      (prog_addr),
      .lock_bits (st_reg.sector_lock),
      .page      (st_reg.page_select[6:0]),
      .page_only (st_reg.erased_ok),
      .allowed   (addr_ok)
   );

   assign opt.data  = opt_rd_data;
   assign opt.valid = opt_rd_valid;

   // **************************
   // address decode
   // **************************
   assign wr_cmd  = reg_wr && reg_addr == FCSP_ADDR_STATE;
   assign wr_page = reg_wr && reg_addr == FCSP_ADDR_PAGE;
   assign wr_hi   = reg_wr && reg_addr == FCSP_ADDR_TIME_H;
   assign wr_lo   = reg_wr && reg_addr == FCSP_ADDR_TIME_L;

   // status code from the one-hot state
   always_comb begin
      unique case (st_reg.fsm)
         FCSP_LOCKED:   code = FCSP_ST_LOCKED; // RQ3
         FCSP_FIRST:    code = FCSP_ST_FIRST;
         FCSP_SECOND:   code = FCSP_ST_SECOND;
         FCSP_UNLOCKED: code = FCSP_ST_UNLOCKED;
         FCSP_PROTSEL:  code = FCSP_ST_PROTSEL; // RQ4
         FCSP_PROG:     code = FCSP_ST_PROG; // RQ5
         FCSP_PAGE_ER:  code = FCSP_ST_PAGE_ER;
         FCSP_MASS_ER:  code = FCSP_ST_MASS_ER;
         default:       code = FCSP_ST_LOCKED;
      endcase
   end

   // **************************
   // next state
   // **************************
   always_comb begin
      st_next         = st_reg;
      st_next.grant   = 1'b0;
      st_next.refused = 1'b0;
      st_next.page_go = 1'b0;
      st_next.mass_go = 1'b0;

      // command sequence
      if (wr_cmd) begin
         unique case (st_reg.fsm)
            FCSP_LOCKED:
               st_next.fsm = reg_wdata == FCSP_CMD_UNLOCK1 ? FCSP_FIRST
                                                           : FCSP_LOCKED; // RQ18
            FCSP_FIRST:
               st_next.fsm = reg_wdata == FCSP_CMD_UNLOCK2 ? FCSP_SECOND
                                                           : FCSP_LOCKED; // RQ18
            FCSP_SECOND, FCSP_UNLOCKED: begin
               st_next.fsm = FCSP_LOCKED;
               if (reg_wdata == FCSP_CMD_PAGE_ER) begin
                  st_next.fsm       = FCSP_PAGE_ER; // RQ21
                  st_next.page_go   = 1'b1;
                  st_next.erased_ok = 1'b1;
               end else if (reg_wdata == FCSP_CMD_MASS_ER) begin
                  st_next.fsm       = FCSP_MASS_ER; // RQ21
                  st_next.mass_go   = 1'b1;
                  st_next.erased_ok = 1'b0;
               end else if (reg_wdata == FCSP_CMD_PROTECT) begin
                  st_next.fsm = FCSP_PROTSEL; // RQ19
               end
            end
            FCSP_PROTSEL:
               st_next.fsm = FCSP_LOCKED;
            default: ;
         endcase
         if (st_next.fsm == FCSP_LOCKED) begin
            st_next.erased_ok = 1'b0;
         end
      end

      // the second unlock value settles into unlocked
      if (!wr_cmd && st_reg.fsm == FCSP_SECOND) begin
         st_next.fsm = FCSP_UNLOCKED; // RQ3
      end

      // shared page / protect address
      if (wr_page) begin
         if (st_reg.fsm == FCSP_PROTSEL) begin
            st_next.sector_lock = st_reg.sector_lock | reg_wdata; // RQ7 RQ12 RQ22
            st_next.fsm         = FCSP_UNLOCKED; // RQ4 RQ7
         end else begin
            st_next.page_select = reg_wdata; // RQ6
         end
      end

      if (wr_hi) begin
         st_next.timing_value_high = reg_wdata;
      end
      if (wr_lo) begin
         st_next.timing_value_low = reg_wdata;
      end

      // byte program after a page erase, inside the erased page
      if (prog_req && st_reg.fsm == FCSP_UNLOCKED && st_reg.erased_ok) begin
         if (addr_ok) begin
            st_next.fsm   = FCSP_PROG;
            st_next.grant = 1'b1;
         end else begin
            st_next.refused = 1'b1; // RQ20
         end
      end else if (prog_req) begin
         st_next.refused = 1'b1;
      end

      // operation end
      if (flash_done) begin
         unique case (st_reg.fsm)
            FCSP_PROG:    st_next.fsm = FCSP_UNLOCKED;
            FCSP_PAGE_ER: st_next.fsm = FCSP_LOCKED;
            FCSP_MASS_ER: st_next.fsm = FCSP_LOCKED;
            default: ;
         endcase
      end

      // page erase refused on a locked sector
      if (st_next.page_go &&
          st_reg.sector_lock[BIG_PART != 0 ? st_reg.page_select[3:1]
                                           : st_reg.page_select[2:0]]) begin // RQ13
         st_next.page_go   = 1'b0; // RQ20
         st_next.fsm       = FCSP_LOCKED;
         st_next.erased_ok = 1'b0;
      end

      // read data
      st_next.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            FCSP_ADDR_STATE:  st_next.rdata = {2'b00, code}; // RQ1 RQ2
            FCSP_ADDR_PAGE:   st_next.rdata = st_reg.fsm == FCSP_PROTSEL
                                              ? st_reg.sector_lock : st_reg.page_select;
            FCSP_ADDR_TIME_H: st_next.rdata = st_reg.timing_value_high;
            FCSP_ADDR_TIME_L: st_next.rdata = st_reg.timing_value_low;
            default:          st_next.rdata = 8'h00;
         endcase
      end
   end

   // **************************
   // state register
   // **************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.fsm               <= FCSP_LOCKED; // RQ23
         st_reg.page_select       <= FCSP_RST_BYTE;
         st_reg.sector_lock       <= FCSP_RST_BYTE; // RQ11
         st_reg.timing_value_high <= FCSP_RST_BYTE;
         st_reg.timing_value_low  <= FCSP_RST_BYTE;
         st_reg.rdata             <= FCSP_RST_BYTE;
         st_reg.grant             <= 1'b0;
         st_reg.refused           <= 1'b0;
         st_reg.page_go           <= 1'b0;
         st_reg.mass_go           <= 1'b0;
         st_reg.erased_ok         <= 1'b0;
      end else if (!opt.done) begin
         st_reg.rdata <= FCSP_RST_BYTE; // hold until options loaded
      end else begin
         st_reg <= st_next;
      end
   end

   // **************************
   // outputs
   // **************************
   logic [15:0] opt_addr_reg;
   logic        opt_req_reg;
   logic        opt_rdy_reg;
   logic [15:0] opt_bits_reg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         opt_addr_reg <= 16'h0000;
         opt_req_reg  <= 1'b0;
         opt_rdy_reg  <= 1'b0;
         opt_bits_reg <= 16'h0000;
      end else begin
         opt_addr_reg <= opt.addr;
         opt_req_reg  <= opt.req;
         opt_rdy_reg  <= opt.done; // RQ17
         opt_bits_reg <= opt_bits;
      end
   end

   assign reg_rdata     = st_reg.rdata;
   assign prog_grant    = st_reg.grant;
   assign prog_refused  = st_reg.refused;
   assign page_erase_go = st_reg.page_go;
   assign mass_erase_go = st_reg.mass_go;
   assign erase_page    = st_reg.page_select[6:0]; // RQ9
   assign info_map_en   = st_reg.page_select[FCSP_INFO_BIT]; // RQ10
   assign timing_value  = {st_reg.timing_value_high, st_reg.timing_value_low}; // RQ14
   assign opt_rd_req    = opt_req_reg;
   assign opt_rd_addr   = opt_addr_reg;
   assign option_bits   = opt_bits_reg;
   assign option_ready  = opt_rdy_reg;
endmodule // fcsp_ctrl

// ---- sim/fcsp_ctrl_properties.sv ----
`timescale 1ns/10ps
// ****
// register side properties
// ****
module fcsp_ctrl_properties
   import fcsp_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        prog_req,
   input wire logic        prog_grant,
   input wire logic        prog_refused,
   input wire logic        page_erase_go,
   input wire logic        mass_erase_go,
   input wire logic [6:0]  erase_page,
   input wire logic        info_map_en,
   input wire logic [15:0] timing_value,
   input wire logic [15:0] option_bits,
   input wire logic        option_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // a write strobe at one register address
   sequence wr_s(logic [11:0] a);
      reg_wr && reg_addr == a;
   endsequence
   // a status read answered one cycle later
   sequence st_rd_s;
      reg_rd && reg_addr == FCSP_ADDR_STATE ##1 1'b1;
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero without a read");
   status_top_a: assert property (st_rd_s |-> reg_rdata[7:6] == 2'b00)
      else $error("status reserved bits not zero");
   page_cause_a: assert property (page_erase_go |->
      $past(reg_wr && reg_addr == FCSP_ADDR_STATE && reg_wdata == FCSP_CMD_PAGE_ER))
      else $error("page erase without its command");
   mass_cause_a: assert property (mass_erase_go |->
      $past(reg_wr && reg_addr == FCSP_ADDR_STATE && reg_wdata == FCSP_CMD_MASS_ER))
      else $error("mass erase without its command");
   grant_cause_a: assert property (prog_grant |-> $past(prog_req))
      else $error("grant without request");
   prog_answer_a: assert property (prog_req |=> prog_grant ^ prog_refused)
      else $error("program request not answered once");
   time_high_a: assert property (wr_s(FCSP_ADDR_TIME_H) |=>
      timing_value[15:8] == $past(reg_wdata))
      else $error("timing high byte not loaded");
   time_low_a: assert property (wr_s(FCSP_ADDR_TIME_L) |=>
      timing_value[7:0] == $past(reg_wdata))
      else $error("timing low byte not loaded");
   time_hold_a: assert property (!(reg_wr && reg_addr[11:1] == 11'h7fd) |=>
      $stable(timing_value))
      else $error("timing value moved without a write");
   page_hold_a: assert property (!(reg_wr && reg_addr == FCSP_ADDR_PAGE) |=>
      $stable({info_map_en, erase_page}))
      else $error("page select moved without a write");
   option_keep_a: assert property (option_ready |=> option_ready && $stable(option_bits))
      else $error("option data not held");
endmodule // fcsp_ctrl_properties

bind fcsp_ctrl fcsp_ctrl_properties fcsp_ctrl_properties_inst (
   .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .prog_req(prog_req),
   .prog_grant(prog_grant), .prog_refused(prog_refused), .page_erase_go(page_erase_go),
   .mass_erase_go(mass_erase_go), .erase_page(erase_page), .info_map_en(info_map_en),
   .timing_value(timing_value), .option_bits(option_bits), .option_ready(option_ready));

// ---- sim/fcsp_flash_model.sv ----
`timescale 1ns/10ps
// ****
// flash array stand-in
// ****
module fcsp_flash_model #(
   parameter logic [7:0] OPT0 = 8'h5a,
   parameter logic [7:0] OPT1 = 8'hc3,
   parameter int         BUSY = 20
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        opt_rd_req,
   input  wire logic [15:0] opt_rd_addr,
   output logic [7:0]       opt_rd_data,
   output logic             opt_rd_valid,
   input  wire logic        start,
   output logic             flash_done
);
   int rd_cnt;
   int op_cnt;
   // option reads answer after two cycles; data scrambles outside the pulse
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_cnt <= 0;
         op_cnt <= 0;
         opt_rd_data <= 8'h00;
         opt_rd_valid <= 1'b0;
         flash_done <= 1'b0;
      end else begin
         opt_rd_valid <= 1'b0;
         flash_done <= 1'b0;
         opt_rd_data <= ~opt_rd_data;
         if (rd_cnt == 2) begin
            opt_rd_valid <= 1'b1;
            opt_rd_data <= opt_rd_addr[0] ? OPT1 : OPT0;
            rd_cnt <= -2;
         end else if (opt_rd_req || rd_cnt < 0) begin
            rd_cnt <= rd_cnt + 1;
         end
         // an erase or a program runs a while, then reports completion
         if (start) begin
            op_cnt <= BUSY;
         end else if (op_cnt == 1) begin
            flash_done <= 1'b1;
            op_cnt <= 0;
         end else if (op_cnt > 1) begin
            op_cnt <= op_cnt - 1;
         end
      end
   end
endmodule // fcsp_flash_model

// ---- sim/tb.sv ----
`timescale 1ns/10ps
// ****
// register side testbench
// ****
module tb
   import fcsp_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        prog_req = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00;
   logic [15:0] prog_addr = 16'h0000;
   logic [7:0]  reg_rdata, opt_rd_data;
   logic [6:0]  erase_page;
   logic [15:0] timing_value, opt_rd_addr, option_bits;
   logic        prog_grant, prog_refused, page_erase_go, mass_erase_go, info_map_en;
   logic        opt_rd_req, opt_rd_valid, option_ready, flash_done;
   int          failures, compares, cyc, n_pg, n_ms, n_rf, n_dn, n_gr, s0, s1, lock, page, r;
   localparam int CLK_KHZ = 40000; // core_clk rate in kilohertz

   fcsp_ctrl fcsp_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .prog_req(prog_req), .prog_addr(prog_addr), .flash_done(flash_done),
      .prog_grant(prog_grant), .prog_refused(prog_refused), .page_erase_go(page_erase_go),
      .mass_erase_go(mass_erase_go), .erase_page(erase_page), .info_map_en(info_map_en),
      .timing_value(timing_value), .opt_rd_req(opt_rd_req), .opt_rd_addr(opt_rd_addr),
      .opt_rd_data(opt_rd_data), .opt_rd_valid(opt_rd_valid), .option_bits(option_bits),
      .option_ready(option_ready));
   fcsp_flash_model fcsp_flash_model_inst (.core_clk(core_clk), .rst_n(rst_n),
      .opt_rd_req(opt_rd_req), .opt_rd_addr(opt_rd_addr), .opt_rd_data(opt_rd_data),
      .opt_rd_valid(opt_rd_valid), .start(page_erase_go | mass_erase_go | prog_grant),
      .flash_done(flash_done));

   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   // pulse counters and hang limit
   always @(posedge core_clk) begin
      n_pg += page_erase_go;
      n_ms += mass_erase_go;
      n_rf += prog_refused;
      n_dn += flash_done;
      n_gr += prog_grant;
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end

   task chk(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [15:0] want);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, want);
   endtask
   task unlock;
      wr(FCSP_ADDR_STATE, FCSP_CMD_UNLOCK1);
      wr(FCSP_ADDR_STATE, FCSP_CMD_UNLOCK2);
   endtask
   task wait_done;
      s0 = n_dn;
      for (int i = 0; i < 200 && n_dn == s0; i++) @(posedge core_clk);
      chk(n_dn - s0, 1);
   endtask
   // one program request pulse, then let the answer pass
   task prog(input logic [15:0] a);
      @(posedge core_clk);
      prog_req <= 1'b1;
      prog_addr <= a;
      @(posedge core_clk);
      prog_req <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // main sequence
   initial begin
      r = $urandom(36);
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 300 && option_ready !== 1'b1; i++) @(posedge core_clk);
      chk(option_bits, 16'hc35a);
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_LOCKED);
      rd_chk(FCSP_ADDR_PAGE, 0);
      rd_chk(FCSP_ADDR_TIME_H, 0);
      rd_chk(12'h0100, 0);
      // timing value bytes
      r = $urandom;
      wr(FCSP_ADDR_TIME_H, r[15:8]);
      wr(FCSP_ADDR_TIME_L, r[7:0]);
      #1 chk(timing_value, r[15:0]);
      rd_chk(FCSP_ADDR_TIME_L, r[7:0]);
      // software loads the clock rate in kilohertz before any erase
      wr(FCSP_ADDR_TIME_H, 8'(CLK_KHZ >> 8));
      wr(FCSP_ADDR_TIME_L, 8'(CLK_KHZ));
      #1 chk(timing_value, 16'(CLK_KHZ));
      // page select while locked, then unlock codes and relock
      page = $urandom_range(255);
      wr(FCSP_ADDR_PAGE, page[7:0]);
      #1 chk({info_map_en, erase_page}, page[7:0]);
      rd_chk(FCSP_ADDR_PAGE, page[7:0]);
      wr(FCSP_ADDR_STATE, FCSP_CMD_UNLOCK1);
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_FIRST);
      wr(FCSP_ADDR_STATE, 8'h11);
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_LOCKED);
      unlock();
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_UNLOCKED);
      // mass erase
      s1 = n_ms;
      wr(FCSP_ADDR_STATE, FCSP_CMD_MASS_ER);
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_MASS_ER);
      wait_done();
      chk(n_ms - s1, 1);
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_LOCKED);
      // sector lock: set, try to clear, set more
      lock = 0;
      for (int k = 0; k < 4; k++) begin
         unlock();
         wr(FCSP_ADDR_STATE, FCSP_CMD_PROTECT);
         rd_chk(FCSP_ADDR_STATE, FCSP_ST_PROTSEL);
         rd_chk(FCSP_ADDR_PAGE, lock[7:0]);
         r = (k == 1) ? 0 : (($urandom & 8'h7e) | (k == 0));
         lock |= r;
         wr(FCSP_ADDR_PAGE, r[7:0]);
         #1 chk({info_map_en, erase_page}, page[7:0]);
         rd_chk(FCSP_ADDR_STATE, FCSP_ST_UNLOCKED);
         page = $urandom_range(255);
         wr(FCSP_ADDR_PAGE, page[7:0]);
         #1 chk({info_map_en, erase_page}, page[7:0]);
         wr(FCSP_ADDR_STATE, 8'h00);
      end
      // page erase in a locked sector, then in a free one
      for (int j = 0; j < 2; j++) begin
         page = j ? (($urandom & 8'hf0) | 8'h0e) : ($urandom & 8'hf1);
         wr(FCSP_ADDR_PAGE, page[7:0]);
         unlock();
         s0 = n_pg;
         s1 = n_rf;
         wr(FCSP_ADDR_STATE, FCSP_CMD_PAGE_ER);
         repeat (2) @(posedge core_clk);
         chk(n_pg - s0, j);
         chk(n_rf - s1, 0);
         if (j == 1) begin
            rd_chk(FCSP_ADDR_STATE, FCSP_ST_PAGE_ER);
            wait_done();
         end
         rd_chk(FCSP_ADDR_STATE, FCSP_ST_LOCKED);
      end
      // byte program inside the erased page, then outside it
      unlock();
      s0 = n_gr;
      prog({page[6:0], 9'($urandom)});
      chk(n_gr - s0, 1);
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_PROG);
      wait_done();
      rd_chk(FCSP_ADDR_STATE, FCSP_ST_UNLOCKED);
      s1 = n_rf;
      prog({page[6:0] ^ 7'h01, 9'($urandom)});
      chk(n_rf - s1, 1);
      wr(FCSP_ADDR_STATE, 8'h00);
      // byte program while locked is refused
      s1 = n_rf;
      prog(16'($urandom));
      chk(n_rf - s1, 1);
      test_done();
   end
endmodule // tb
